//--- rtl/ops_output_three.sv
// output-three product-two select registers and output decision
// assumes product one is computed elsewhere and arrives as i_product_one;
// assumes all inputs are synchronous to i_core_clk
//
// Summary of operation
// (RQ1) Bits 0-3 of register 19 add primary undervoltage of detectors one to four to the term.
// (RQ2) Bits 4-5 of register 19 add detectors five and six only on the larger variant.
// (RQ3) Bits 6-7 of register 19 add watchdog timers one and two to the term.
// (RQ4) Bits 0-5 of register 1A add secondary thresholds of detectors one to six, five and six only on the larger variant.
// (RQ5) Bits 6-7 of register 1A add logic inputs one and two to the term.
// (RQ6) Bits 0-1 of register 1B add logic inputs three and four to the term.
// (RQ7) Bits 2-3 of register 1B add sequenced outputs one and two on the larger variant.
// (RQ8) Bits 4-7 of register 1B add sequenced outputs four to seven to the term.
// (RQ9) Bit 1 of register 1C adds sequenced output eight on the larger variant.
// (RQ10) Bit 2 of register 40 asserts the output while the manual reset input is low.
// (RQ11) A cleared select bit removes its signal from the term entirely.
// (RQ12) The output deasserts when either product term is true and no manual reset hold applies, and stays asserted otherwise.
// (RQ13) Each term is the AND of selected conditions, each true only when healthy.
// (RQ14) Unselected conditions count as one and an empty term is never true.
`default_nettype none

module ops_output_three #(
	parameter bit LARGE_VARIANT = 1'b1 // 1 = six detectors, eight outputs
) (
	input  wire logic       i_core_clk,                 // 125 MHz core clock
	input  wire logic       i_sys_rst,                  // sync reset, active high
	// register port
	input  wire logic       i_cfg_wr_en,                // write strobe, one cycle
	input  wire logic       i_cfg_rd_en,                // read strobe, one cycle
	input  wire logic [7:0] i_cfg_addr,                 // register offset
	input  wire logic [7:0] i_cfg_wdata,                // write data
	output logic      [7:0] o_cfg_rdata,                // read data, registered
	output logic            o_cfg_rvalid,               // read data valid pulse
	// monitored conditions
	input  wire logic [5:0] i_detector_primary_ok,      // detector above primary threshold
	input  wire logic [5:0] i_detector_secondary_ok,    // detector within secondary threshold
	input  wire logic [1:0] i_watchdog_timer_expired,   // watchdog one, two expired
	input  wire logic [3:0] i_logic_input_active,       // logic inputs one to four active
	input  wire logic [7:0] i_sequenced_output_released,// outputs one to eight deasserted
	input  wire logic       i_manual_reset_n,           // manual reset, active low
	input  wire logic       i_product_one,              // product one term true
	// results
	output logic            o_sequenced_output_three,   // 1 = asserted
	output logic            o_product_two,              // product two term true
	output logic            o_manual_reset_hold         // output held by manual reset
);
	import ops_pkg::*;

	// ***********************************************************
	// register state
	// ***********************************************************
	logic [7:0] sel_primary_reg;
	logic [7:0] sel_primary_next;
	logic [7:0] sel_secondary_reg;
	logic [7:0] sel_secondary_next;
	logic [7:0] sel_in_out_reg;
	logic [7:0] sel_in_out_next;
	logic [7:0] sel_out_eight_reg;
	logic [7:0] sel_out_eight_next;
	logic [7:0] mr_map_reg;
	logic [7:0] mr_map_next;
	logic [7:0] rdata_reg;
	logic [7:0] rdata_next;
	logic       rvalid_reg;
	logic       rvalid_next;
	logic       out_reg;
	logic       out_next;
	logic       p2_reg;
	logic       p2_next;
	logic       mr_hold_reg;
	logic       mr_hold_next;

	// ***********************************************************
	// helpers
	// ***********************************************************
	// limit a select byte to the bits the fitted variant has
	function automatic logic [7:0] variant_mask(input logic [7:0] value,
		input logic [7:0] small_mask);
		variant_mask = LARGE_VARIANT ? value : (value & small_mask);
	endfunction

	// read mux for the stored registers
	function automatic logic [7:0] read_reg(input logic [7:0] addr,
		input logic [7:0] r19, input logic [7:0] r1a, input logic [7:0] r1b,
		input logic [7:0] r1c, input logic [7:0] r40);
		if (addr == OPS_ADDR_SEL_PRIMARY) begin
			read_reg = r19;
		end else if (addr == OPS_ADDR_SEL_SECONDARY) begin
			read_reg = r1a;
		end else if (addr == OPS_ADDR_SEL_IN_OUT) begin
			read_reg = r1b;
		end else if (addr == OPS_ADDR_SEL_OUT_EIGHT) begin
			read_reg = r1c;
		end else if (addr == OPS_ADDR_MR_MAP) begin
			read_reg = r40;
		end else begin
			read_reg = OPS_RDATA_UNMAPPED;
		end
	endfunction

	// ***********************************************************
	// register writes and reads
	// ***********************************************************
	// decode write strobe into the addressed register
	always_comb begin
		sel_primary_next   = sel_primary_reg;
		sel_secondary_next = sel_secondary_reg;
		sel_in_out_next    = sel_in_out_reg;
		sel_out_eight_next = sel_out_eight_reg;
		mr_map_next        = mr_map_reg;
		if (i_cfg_wr_en) begin
			if (i_cfg_addr == OPS_ADDR_SEL_PRIMARY) begin
				sel_primary_next = i_cfg_wdata;
			end else if (i_cfg_addr == OPS_ADDR_SEL_SECONDARY) begin
				sel_secondary_next = i_cfg_wdata;
			end else if (i_cfg_addr == OPS_ADDR_SEL_IN_OUT) begin
				sel_in_out_next = i_cfg_wdata;
			end else if (i_cfg_addr == OPS_ADDR_SEL_OUT_EIGHT) begin
				sel_out_eight_next = i_cfg_wdata;
			end else if (i_cfg_addr == OPS_ADDR_MR_MAP) begin
				mr_map_next = i_cfg_wdata;
			end
		end
		rvalid_next = i_cfg_rd_en;
		rdata_next  = rdata_reg;
		if (i_cfg_rd_en) begin
			rdata_next = read_reg(i_cfg_addr, sel_primary_reg, sel_secondary_reg,
				sel_in_out_reg, sel_out_eight_reg, mr_map_reg);
		end
	end

	// register the configuration and read path
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			sel_primary_reg   <= OPS_REG_RESET;
			sel_secondary_reg <= OPS_REG_RESET;
			sel_in_out_reg    <= OPS_REG_RESET;
			sel_out_eight_reg <= OPS_REG_RESET;
			mr_map_reg        <= OPS_REG_RESET;
			rdata_reg         <= OPS_REG_RESET;
			rvalid_reg        <= 1'b0;
		end else begin
			sel_primary_reg   <= sel_primary_next;
			sel_secondary_reg <= sel_secondary_next;
			sel_in_out_reg    <= sel_in_out_next;
			sel_out_eight_reg <= sel_out_eight_next;
			mr_map_reg        <= mr_map_next;
			rdata_reg         <= rdata_next;
			rvalid_reg        <= rvalid_next;
		end
	end

	// ***********************************************************
	// condition and select vectors
	// ***********************************************************
	logic [OPS_COND_W-1:0] select_vec;
	logic [OPS_COND_W-1:0] healthy_vec;
	logic [7:0]            sel19_eff;
	logic [7:0]            sel1a_eff;
	logic [7:0]            sel1b_eff;
	logic [7:0]            sel1c_eff;
	logic                  product_two;

	// variant masking of select bits
	always_comb begin
		sel19_eff = variant_mask(sel_primary_reg, OPS_SMALL_MASK_19);   // [RQ2]
		sel1a_eff = variant_mask(sel_secondary_reg, OPS_SMALL_MASK_1A); // [RQ4]
		sel1b_eff = variant_mask(sel_in_out_reg, OPS_SMALL_MASK_1B);    // [RQ7]
		sel1c_eff = variant_mask(sel_out_eight_reg, OPS_SMALL_MASK_1C); // [RQ9]
		select_vec = {sel1c_eff[OPS_BIT_OUT_EIGHT], sel1b_eff, sel1a_eff, sel19_eff};
	end

	// healthy flags, in the same bit order as the selects
	always_comb begin
		healthy_vec[3:0]   = i_detector_primary_ok[3:0];          // [RQ1]
		healthy_vec[5:4]   = i_detector_primary_ok[5:4];          // [RQ2]
		healthy_vec[7:6]   = ~i_watchdog_timer_expired;           // [RQ3]
		healthy_vec[13:8]  = i_detector_secondary_ok;             // [RQ4]
		healthy_vec[15:14] = ~i_logic_input_active[1:0];          // [RQ5]
		healthy_vec[17:16] = ~i_logic_input_active[3:2];          // [RQ6]
		healthy_vec[19:18] = i_sequenced_output_released[1:0];    // [RQ7]
		healthy_vec[23:20] = i_sequenced_output_released[6:3];    // [RQ8]
		healthy_vec[24]    = i_sequenced_output_released[7];      // [RQ9]
	end

	// product two evaluation
	ops_product_term u_product_two (
		.i_select  (select_vec),
		.i_healthy (healthy_vec),
		.o_true    (product_two)
	);

	// ***********************************************************
	// output decision
	// ***********************************************************
	// release when either term true; manual reset forces assertion
	always_comb begin
		mr_hold_next = mr_map_reg[OPS_BIT_MR_MAP] && !i_manual_reset_n; // [RQ10]
		p2_next      = product_two;
		if (mr_hold_next) begin
			out_next = OPS_OUT_ASSERTED;                                 // [RQ10]
		end else if (i_product_one || product_two) begin
			out_next = OPS_OUT_DEASSERTED;                               // [RQ12]
		end else begin
			out_next = OPS_OUT_ASSERTED;                                 // [RQ12]
		end
	end

	// register the output state
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			out_reg     <= OPS_OUT_ASSERTED;
			p2_reg      <= 1'b0;
			mr_hold_reg <= 1'b0;
		end else begin
			out_reg     <= out_next;
			p2_reg      <= p2_next;
			mr_hold_reg <= mr_hold_next;
		end
	end

	// drive outputs from flops
	assign o_sequenced_output_three = out_reg;
	assign o_product_two            = p2_reg;
	assign o_manual_reset_hold      = mr_hold_reg;
	assign o_cfg_rdata              = rdata_reg;
	assign o_cfg_rvalid             = rvalid_reg;

endmodule // ops_output_three

`default_nettype wire

//--- rtl/ops_pkg.sv
// package for the output-three product-two select block
// assumes a single 125 MHz core clock and a byte-wide register port
`default_nettype none

package ops_pkg;

	// ***********************************************************
	// register offsets
	// ***********************************************************
	localparam logic [7:0] OPS_ADDR_SEL_PRIMARY   = 8'h19; // primary thresholds, watchdogs
	localparam logic [7:0] OPS_ADDR_SEL_SECONDARY = 8'h1A; // secondary thresholds, inputs 1-2
	localparam logic [7:0] OPS_ADDR_SEL_IN_OUT    = 8'h1B; // inputs 3-4, other outputs
	localparam logic [7:0] OPS_ADDR_SEL_OUT_EIGHT = 8'h1C; // output eight select
	localparam logic [7:0] OPS_ADDR_MR_MAP        = 8'h40; // manual-reset mapping

	// ***********************************************************
	// field positions and reset values
	// ***********************************************************
	localparam int         OPS_BIT_OUT_EIGHT = 1;     // bit within 1C
	localparam int         OPS_BIT_MR_MAP    = 2;     // bit within 40
	localparam logic [7:0] OPS_REG_RESET     = 8'h00; // every select cleared
	localparam logic [7:0] OPS_RDATA_UNMAPPED = 8'h00; // unmapped read value
	localparam int         OPS_COND_W        = 25;    // width of condition vector

	// bits allowed on the smaller variant, per select register
	localparam logic [7:0] OPS_SMALL_MASK_19 = 8'hCF; // no detectors five, six
	localparam logic [7:0] OPS_SMALL_MASK_1A = 8'hCF; // no detectors five, six
	localparam logic [7:0] OPS_SMALL_MASK_1B = 8'hF3; // no outputs one, two
	localparam logic [7:0] OPS_SMALL_MASK_1C = 8'hFD; // no output eight

	// output level codes
	localparam logic OPS_OUT_ASSERTED   = 1'b1; // output in its reset/fault state
	localparam logic OPS_OUT_DEASSERTED = 1'b0; // output released

endpackage : ops_pkg

`default_nettype wire

//--- rtl/ops_product_term.sv
// one product term: AND of selected healthy conditions
// assumes conditions are already synchronous and active high when healthy
`default_nettype none

module ops_product_term (
	input  wire logic [ops_pkg::OPS_COND_W-1:0] i_select,  // one bit per condition
	input  wire logic [ops_pkg::OPS_COND_W-1:0] i_healthy, // condition healthy flags
	output logic                                o_true     // term evaluates true
);
	import ops_pkg::*;

	// ***********************************************************
	// term evaluation
	// ***********************************************************
	// unselected bits force one; empty selection never true
	always_comb begin
		o_true = (&(i_healthy | ~i_select)) && (|i_select); // [RQ11] [RQ13] [RQ14]
	end

endmodule // ops_product_term

`default_nettype wire

//--- verif/ops_cond_model.sv
// far-side model: detectors, logic inputs, watchdogs, other outputs
// assumes one fault bit per condition position, 1 = unhealthy
`default_nettype none

module ops_cond_model (
	input  wire logic        i_core_clk,     // clock
	input  wire logic [24:0] i_fault,        // conditions to break
	output logic      [5:0]  o_primary_ok = '1,   // above primary
	output logic      [5:0]  o_secondary_ok = '1, // secondary fine
	output logic      [1:0]  o_wd_expired = '0,   // watchdogs
	output logic      [3:0]  o_logic_active = '0, // logic inputs
	output logic      [7:0]  o_released = '1      // outputs released
);
	// pin levels change only at a clock edge
	always @(posedge i_core_clk) begin
		o_primary_ok   <= ~i_fault[5:0];
		o_wd_expired   <= i_fault[7:6];
		o_secondary_ok <= ~i_fault[13:8];
		o_logic_active <= i_fault[17:14];
		o_released     <= ~{i_fault[24:20], 1'b0, i_fault[19:18]};
	end
endmodule // ops_cond_model

`default_nettype wire

//--- verif/ops_output_three_sva.sv
// checker for the output-three product-two block
// assumes it is bound to ops_output_three
`default_nettype none

module ops_output_three_sva import ops_pkg::*; #(
	parameter bit LARGE_VARIANT = 1'b1 // variant
) (
	input wire logic       i_core_clk,                  // clock
	input wire logic       i_sys_rst,                   // reset
	input wire logic       i_cfg_wr_en,                 // write
	input wire logic       i_cfg_rd_en,                 // read
	input wire logic [7:0] i_cfg_addr,                  // offset
	input wire logic [7:0] i_cfg_wdata,                 // data in
	input wire logic [7:0] o_cfg_rdata,                 // data out
	input wire logic       o_cfg_rvalid,                // read valid
	input wire logic [5:0] i_detector_primary_ok,       // primary
	input wire logic [5:0] i_detector_secondary_ok,     // secondary
	input wire logic [1:0] i_watchdog_timer_expired,    // watchdogs
	input wire logic [3:0] i_logic_input_active,        // logic inputs
	input wire logic [7:0] i_sequenced_output_released, // outputs
	input wire logic       i_manual_reset_n,            // manual reset
	input wire logic       i_product_one,               // term one
	input wire logic       o_sequenced_output_three,    // output
	input wire logic       o_product_two,               // term two
	input wire logic       o_manual_reset_hold          // held
);
	logic [7:0]  r19, r1a, r1b, r1c, r40, rd_exp;
	logic [24:0] sel, hl;
	logic        rst_d, emp, bad;
	// shadow copy of the registers
	always_ff @(posedge i_core_clk) begin
		rst_d <= i_sys_rst;
		if (i_sys_rst) begin
			{r19, r1a, r1b, r1c, r40} <= '0;
		end else if (i_cfg_wr_en) begin
			case (i_cfg_addr)
			OPS_ADDR_SEL_PRIMARY: r19 <= i_cfg_wdata;
			OPS_ADDR_SEL_SECONDARY: r1a <= i_cfg_wdata;
			OPS_ADDR_SEL_IN_OUT: r1b <= i_cfg_wdata;
			OPS_ADDR_SEL_OUT_EIGHT: r1c <= i_cfg_wdata;
			OPS_ADDR_MR_MAP: r40 <= i_cfg_wdata;
			default: ;
			endcase
		end
	end
	// expected term, read data
	always_comb begin
		sel = {r1c[1] & LARGE_VARIANT, r1b, r1a, r19};
		if (!LARGE_VARIANT) begin
			sel = sel & {1'b0, OPS_SMALL_MASK_1B, OPS_SMALL_MASK_1A, OPS_SMALL_MASK_19};
		end
		hl = {i_sequenced_output_released[7:3], i_sequenced_output_released[1:0],
			~i_logic_input_active, i_detector_secondary_ok, ~i_watchdog_timer_expired,
			i_detector_primary_ok};
		emp = (sel == '0);
		bad = ((sel & ~hl) != '0);
		case (i_cfg_addr)
		OPS_ADDR_SEL_PRIMARY: rd_exp = r19;
		OPS_ADDR_SEL_SECONDARY: rd_exp = r1a;
		OPS_ADDR_SEL_IN_OUT: rd_exp = r1b;
		OPS_ADDR_SEL_OUT_EIGHT: rd_exp = r1c;
		OPS_ADDR_MR_MAP: rd_exp = r40;
		default: rd_exp = OPS_RDATA_UNMAPPED;
		endcase
	end
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (i_sys_rst);
	a_term_matches_sel: assert property (!rst_d |-> o_product_two == !$past(emp | bad))
		else $error("product two differs from selection");
	a_unhealthy_blocks: assert property (!rst_d && $past(bad) |-> !o_product_two)
		else $error("unhealthy selected condition ignored");
	a_healthy_passes: assert property (!rst_d && $past(!emp) && $past(!bad) |-> o_product_two)
		else $error("unselected condition affects term");
	a_empty_never_true: assert property (!rst_d && $past(emp) |-> !o_product_two)
		else $error("empty term true");
	a_out_from_terms: assert property (!rst_d && !o_manual_reset_hold |->
		o_sequenced_output_three == !($past(i_product_one) | o_product_two))
		else $error("output differs from terms");
	a_mr_hold_cause: assert property (!rst_d |->
		o_manual_reset_hold == $past(!i_manual_reset_n & r40[OPS_BIT_MR_MAP]))
		else $error("manual reset hold wrong");
	a_mr_forces_out: assert property (o_manual_reset_hold |-> o_sequenced_output_three)
		else $error("output released under manual reset");
	a_read_returns: assert property (i_cfg_rd_en |=> o_cfg_rvalid && o_cfg_rdata == $past(rd_exp))
		else $error("read data or valid wrong");
	a_no_stray_valid: assert property (!i_cfg_rd_en |=> !o_cfg_rvalid)
		else $error("read valid without a read");
	a_rdata_holds: assert property (!i_cfg_rd_en |=> $stable(o_cfg_rdata))
		else $error("read data changed without a read");
endmodule // ops_output_three_sva

bind ops_output_three ops_output_three_sva #(.LARGE_VARIANT(LARGE_VARIANT)) u_sva (
	.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_cfg_wr_en(i_cfg_wr_en),
	.i_cfg_rd_en(i_cfg_rd_en), .i_cfg_addr(i_cfg_addr), .i_cfg_wdata(i_cfg_wdata),
	.o_cfg_rdata(o_cfg_rdata), .o_cfg_rvalid(o_cfg_rvalid),
	.i_detector_primary_ok(i_detector_primary_ok),
	.i_detector_secondary_ok(i_detector_secondary_ok),
	.i_watchdog_timer_expired(i_watchdog_timer_expired),
	.i_logic_input_active(i_logic_input_active),
	.i_sequenced_output_released(i_sequenced_output_released),
	.i_manual_reset_n(i_manual_reset_n), .i_product_one(i_product_one),
	.o_sequenced_output_three(o_sequenced_output_three),
	.o_product_two(o_product_two), .o_manual_reset_hold(o_manual_reset_hold));

`default_nettype wire

//--- verif/test_ops_output_three.sv
// testbench for the output-three product-two block
// assumes the design, its checker and ops_cond_model
`default_nettype none

module test_ops_output_three import ops_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {
		logic [31:0] sel;
		logic [24:0] flt;
		logic        p1, p2;
	} ops_row_t;
	logic       i_core_clk = 0, i_sys_rst = 1, i_cfg_wr_en = 0, i_cfg_rd_en = 0;
	logic [7:0] i_cfg_addr = 8'h00, i_cfg_wdata = 8'h00, o_cfg_rdata, rdv;
	logic       i_manual_reset_n = 1, i_product_one = 0, o_cfg_rvalid;
	logic       o_sequenced_output_three, o_product_two, o_manual_reset_hold;
	logic [7:0] sm_rdata;
	logic       sm_rvalid, sm_out, sm_p2, sm_hold;
	logic [5:0] i_detector_primary_ok, i_detector_secondary_ok;
	logic [1:0] i_watchdog_timer_expired;
	logic [3:0] i_logic_input_active;
	logic [7:0] i_sequenced_output_released;
	logic [24:0] flt = '0;
	int         mismatches = 0, checked = 0, cycles = 0;
	ops_row_t   rows [17] = '{
		'{32'h00000000, 25'h0, 1'b0, 1'b0}, '{32'h0000000F, 25'h0, 1'b0, 1'b1},
		'{32'h0000000F, 25'h4, 1'b0, 1'b0}, '{32'h00000030, 25'h20, 1'b0, 1'b0},
		'{32'h000000C0, 25'h40, 1'b0, 1'b0}, '{32'h00000080, 25'h40, 1'b0, 1'b1},
		'{32'h00003F00, 25'h1000, 1'b0, 1'b0}, '{32'h0000C000, 25'h8000, 1'b0, 1'b0},
		'{32'h00030000, 25'h10000, 1'b0, 1'b0}, '{32'h000C0000, 25'h80000, 1'b0, 1'b0},
		'{32'h00F00000, 25'h0, 1'b0, 1'b1}, '{32'h00F00000, 25'h800000, 1'b0, 1'b0},
		'{32'h02000000, 25'h1000000, 1'b0, 1'b0}, '{32'h02000000, 25'h0, 1'b0, 1'b1},
		'{32'hFD000000, 25'h0, 1'b0, 1'b0}, '{32'h0000000F, 25'h0, 1'b1, 1'b1},
		'{32'h00000000, 25'h0, 1'b1, 1'b0}};

	ops_output_three #(.LARGE_VARIANT(1'b1)) dut_u (
		.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_cfg_wr_en(i_cfg_wr_en),
		.i_cfg_rd_en(i_cfg_rd_en), .i_cfg_addr(i_cfg_addr), .i_cfg_wdata(i_cfg_wdata),
		.o_cfg_rdata(o_cfg_rdata), .o_cfg_rvalid(o_cfg_rvalid),
		.i_detector_primary_ok(i_detector_primary_ok),
		.i_detector_secondary_ok(i_detector_secondary_ok),
		.i_watchdog_timer_expired(i_watchdog_timer_expired),
		.i_logic_input_active(i_logic_input_active),
		.i_sequenced_output_released(i_sequenced_output_released),
		.i_manual_reset_n(i_manual_reset_n), .i_product_one(i_product_one),
		.o_sequenced_output_three(o_sequenced_output_three),
		.o_product_two(o_product_two), .o_manual_reset_hold(o_manual_reset_hold));
	// smaller variant on the same bus and pins
	ops_output_three #(.LARGE_VARIANT(1'b0)) dut_small_u (
		.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_cfg_wr_en(i_cfg_wr_en),
		.i_cfg_rd_en(i_cfg_rd_en), .i_cfg_addr(i_cfg_addr), .i_cfg_wdata(i_cfg_wdata),
		.o_cfg_rdata(sm_rdata), .o_cfg_rvalid(sm_rvalid),
		.i_detector_primary_ok(i_detector_primary_ok),
		.i_detector_secondary_ok(i_detector_secondary_ok),
		.i_watchdog_timer_expired(i_watchdog_timer_expired),
		.i_logic_input_active(i_logic_input_active),
		.i_sequenced_output_released(i_sequenced_output_released),
		.i_manual_reset_n(i_manual_reset_n), .i_product_one(i_product_one),
		.o_sequenced_output_three(sm_out), .o_product_two(sm_p2),
		.o_manual_reset_hold(sm_hold));
	ops_cond_model cond_u (.i_core_clk(i_core_clk), .i_fault(flt),
		.o_primary_ok(i_detector_primary_ok), .o_secondary_ok(i_detector_secondary_ok),
		.o_wd_expired(i_watchdog_timer_expired), .o_logic_active(i_logic_input_active),
		.o_released(i_sequenced_output_released));

	// 125 MHz clock
	always #4 i_core_clk = ~i_core_clk;
	// hang guard
	always @(posedge i_core_clk) begin
		cycles++;
		if (cycles == 3000) begin
			mismatches++;
			print_verdict();
		end
	end

	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		checked++;
		if (g !== e) begin
			mismatches++;
			$display("unexpected at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_core_clk);
		i_cfg_addr <= a;
		i_cfg_wdata <= d;
		i_cfg_wr_en <= 1'b1;
		@(posedge i_core_clk);
		i_cfg_wr_en <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge i_core_clk);
		i_cfg_addr <= a;
		i_cfg_rd_en <= 1'b1;
		@(posedge i_core_clk);
		i_cfg_rd_en <= 1'b0;
		#1;
		chk(o_cfg_rvalid, 1'b1);
		rdv = o_cfg_rdata;
	endtask
	task automatic settle();
		repeat (3) @(posedge i_core_clk);
		#1;
	endtask
	task automatic print_verdict();
		$display("mismatches %0d checked %0d", mismatches, checked);
		if (mismatches == 0 && checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// table rows, then readback, manual reset and a second reset
	initial begin
		repeat (16) @(posedge i_core_clk);
		i_sys_rst <= 1'b0;
		rd(OPS_ADDR_SEL_PRIMARY);
		chk(rdv, OPS_REG_RESET);
		foreach (rows[n]) begin
			wr(OPS_ADDR_SEL_PRIMARY, rows[n].sel[7:0]);
			wr(OPS_ADDR_SEL_SECONDARY, rows[n].sel[15:8]);
			wr(OPS_ADDR_SEL_IN_OUT, rows[n].sel[23:16]);
			wr(OPS_ADDR_SEL_OUT_EIGHT, rows[n].sel[31:24]);
			flt <= rows[n].flt;
			i_product_one <= rows[n].p1;
			settle();
			chk(o_product_two, rows[n].p2);
			chk(o_sequenced_output_three, !(rows[n].p1 | rows[n].p2));
		end
		// variant-only bits: counted on the larger part, dropped on the smaller
		wr(OPS_ADDR_SEL_PRIMARY, 8'h30);
		i_product_one <= 1'b0;
		wr(OPS_ADDR_SEL_IN_OUT, 8'h0C);
		wr(OPS_ADDR_SEL_OUT_EIGHT, 8'h02);
		settle();
		chk(o_product_two, 1'b1);
		chk(sm_p2, 1'b0);
		chk(sm_out, 1'b1);
		rd(OPS_ADDR_SEL_IN_OUT);
		chk(sm_rvalid, 1'b1);
		chk(sm_rdata, 8'h0C);
		wr(OPS_ADDR_SEL_SECONDARY, 8'hA5);
		rd(OPS_ADDR_SEL_SECONDARY);
		chk(rdv, 8'hA5);
		wr(8'h41, 8'hFF);
		rd(8'h41);
		chk(rdv, OPS_RDATA_UNMAPPED);
		wr(OPS_ADDR_MR_MAP, 8'hFB);
		i_manual_reset_n <= 1'b0;
		settle();
		chk(o_sequenced_output_three, 1'b0);
		wr(OPS_ADDR_MR_MAP, 8'h04);
		settle();
		chk(o_sequenced_output_three, 1'b1);
		chk(o_manual_reset_hold, 1'b1);
		chk(sm_hold, 1'b1);
		@(posedge i_core_clk);
		i_manual_reset_n <= 1'b1;
		settle();
		chk(o_sequenced_output_three, 1'b0);
		@(posedge i_core_clk);
		i_sys_rst <= 1'b1;
		repeat (2) @(posedge i_core_clk);
		i_sys_rst <= 1'b0;
		rd(OPS_ADDR_MR_MAP);
		chk(rdv, OPS_REG_RESET);
		print_verdict();
	end
endmodule // test_ops_output_three

`default_nettype wire
